// ### dv/dtc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_mem_model (
  input  wire logic                   pclk,       // system clock
  input  wire logic                   presetn,    // async reset, active low
  input  wire logic                   mem_req,    // cycle request
  input  wire logic                   mem_we,     // write cycle
  input  wire logic [dtc_pkg::AW-1:0] mem_addr,   // cycle address
  input  wire logic [dtc_pkg::DW-1:0] mem_wdata,  // write data
  output logic [dtc_pkg::DW-1:0]      mem_rdata,  // read data
  output logic                        mem_ready   // cycle done
);
  logic [1:0]              wait_reg;
  logic [dtc_pkg::DW-1:0]  last_reg;
  int                      since;
  int                      gap_err;
  logic [dtc_pkg::AW-1:0]  waddr_q[$];
  logic [dtc_pkg::DW-1:0]  wdata_q[$];
  wire                     rd_fire = mem_req && mem_ready && !mem_we;
  wire                     wr_fire = mem_req && mem_ready && mem_we;
  // random 0..2 wait states, so both prompt and slow answers occur
  assign mem_ready = mem_req && (wait_reg == 2'h0);
  // idle data line shows the inverse, a stale value never looks valid
  assign mem_rdata = rd_fire ? {mem_addr[7:0] ^ 8'ha5, mem_addr[7:0]}
                             : ~last_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 2'h0;
      last_reg <= 16'h0000;
      since    <= -1;
      gap_err  <= 0;
    end else begin
      if (!mem_req) wait_reg <= 2'($urandom_range(0, 2));
      else if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
      if (rd_fire) last_reg <= mem_rdata;
      // idle clocks between read completion and the write request
      if (mem_req && mem_we && since >= 0) begin
        if (since != 1) gap_err <= gap_err + 1;
        since <= -1;
      end else if (rd_fire) since <= 0;
      else if (since >= 0 && !mem_req) since <= since + 1;
      if (wr_fire) begin
        waddr_q.push_back(mem_addr);
        wdata_q.push_back(mem_wdata);
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/test_dtc_dma.sv
`timescale 1ns/1ps
`default_nettype none
module test_dtc_dma;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  periph_irq;
  logic [3:0]  ext_req_pin, xfer_done;
  logic        mem_req, mem_we, mem_size16, mem_ready, bus_busy, e;
  logic [25:0] mem_addr, src, dst, sv[4], dv[4];
  logic [15:0] mem_wdata, mem_rdata, cv[4];
  logic [4:0]  adc;
  int          num_errors, checks_done, seed, c, n, k;

  dtc_dma dtc_dma_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .ext_req_pin(ext_req_pin), .mem_req(mem_req),
    .mem_we(mem_we), .mem_size16(mem_size16), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .bus_busy(bus_busy), .xfer_done(xfer_done));
  dtc_mem_model dtc_mem_model_inst (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input int w, input logic [11:0] a,
                     input logic [31:0] d);
    int m;
    m = 0;
    psel <= 1'b1;
    pwrite <= 1'(w);
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // pready looked at mid-cycle, where it has settled before the edge
    do begin
      @(negedge pclk);
      m++;
    end while (pready !== 1'b1 && m < 40);
    r = prdata;
    e = pslverr;
    if (m >= 40) num_errors++;
    // the edge that samples pready high; only then is the request dropped
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [11:0] rg(input int ch, input int idx);
    return {5'h00, 2'(ch), 3'(idx), 2'b00};
  endfunction

  function automatic logic [25:0] stp(input logic [25:0] a,
      input logic [1:0] m, input logic s16, input int i);
    if (m == dtc_pkg::AM_INC) return a + 26'(i * (s16 ? 2 : 1));
    if (m == dtc_pkg::AM_DEC) return a - 26'(i * (s16 ? 2 : 1));
    return a;
  endfunction

  task automatic prog(input int ch, input logic [15:0] cnt,
                      input logic [4:0] trg);
    apb(1, rg(ch, 0), {6'h00, src});
    apb(1, rg(ch, 1), {6'h00, dst});
    apb(1, rg(ch, 2), {16'h0000, cnt});
    apb(1, rg(ch, 3), {27'h0, adc});
    apb(1, rg(ch, 5), {27'h0, trg});
  endtask

  task automatic wait_done(input int ch);
    int m;
    m = 0;
    // one-cycle pulse, looked at mid-cycle while it stands
    do begin
      @(negedge pclk);
      m++;
    end while (xfer_done[ch] !== 1'b1 && m < 3000);
    @(posedge pclk);
    chk(m < 3000, 1);
  endtask

  // compare logged writes against the expected source/destination walk
  task automatic units(input int cnt);
    logic [25:0] sa;
    logic [15:0] md;
    md = adc[0] ? 16'hffff : 16'h00ff;
    for (int i = 0; i < cnt; i++) begin
      sa = stp(src, adc[2:1], adc[0], i);
      chk(dtc_mem_model_inst.waddr_q.pop_front(),
          stp(dst, adc[4:3], adc[0], i));
      chk(dtc_mem_model_inst.wdata_q.pop_front() & md,
          {sa[7:0] ^ 8'ha5, sa[7:0]} & md);
    end
  endtask

  task automatic pulse(input int bit_no);
    periph_irq <= 8'h01 << bit_no;
    @(posedge pclk);
    periph_irq <= 8'h00;
  endtask

  initial begin
    seed = $urandom(52);
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {periph_irq, ext_req_pin, adc} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int ch = 0; ch < 4; ch++)
      for (int i = 0; i < 6; i++) begin
        apb(0, rg(ch, 3'(i)), 0);
        chk(r, 0);
      end
    apb(1, 12'h018, 32'hffff_ffff);
    chk(e, 1);
    apb(0, 12'h018, 0);
    chk(e, 1);
    chk(r, 0);
    for (int ch = 0; ch < 4; ch++) begin
      sv[ch] = 26'($urandom); dv[ch] = 26'($urandom); cv[ch] = 16'($urandom);
      src = sv[ch]; dst = dv[ch];
      prog(ch, cv[ch], 5'h10);
    end
    for (int ch = 0; ch < 4; ch++) begin
      apb(0, rg(ch, 0), 0);
      chk(r, {6'h00, sv[ch]});
      apb(0, rg(ch, 1), 0);
      chk(r, {6'h00, dv[ch]});
      apb(0, rg(ch, 2), 0);
      chk(r, {16'h0000, cv[ch]});
    end
    for (int sm = 0; sm < 3; sm++)
      for (int dm = 0; dm < 3; dm++) begin
        c = $urandom % 4; n = 1 + $urandom % 4;
        adc = {2'(dm), 2'(sm), 1'($urandom)};
        src = 26'h100 + 26'($urandom % 64);
        dst = 26'h300 + 26'($urandom % 64);
        prog(c, 16'(n), 5'h10);
        apb(1, rg(c, 4), 32'h0000_0009);
        wait_done(c);
        chk(mem_size16, adc[0]);
        units(n);
        apb(0, rg(c, 4), 0);
        chk(r, 32'h0000_000a);
        apb(0, rg(c, 2), 0);
        chk(r, 0);
        apb(0, rg(c, 0), 0);
        chk(r, {6'h00, stp(src, adc[2:1], adc[0], n)});
        apb(1, rg(c, 4), 32'h0000_0002);
      end
    adc = 5'h01; src = 26'h040; dst = 26'h080;
    prog(1, 16'h0002, 5'h10);
    apb(1, rg(1, 4), 32'h0000_0001);
    apb(1, rg(1, 4), 32'h0000_0005);
    repeat (40) @(posedge pclk);
    chk(dtc_mem_model_inst.waddr_q.size(), 1);
    chk(bus_busy, 0);
    apb(1, rg(1, 4), 32'h0000_0005);
    wait_done(1);
    units(2);
    k = $urandom % 8; adc = 5'h00;
    prog(2, 16'h0001, 5'(k));
    apb(1, rg(2, 4), 32'h0000_0001);
    pulse((k + 1) % 8);
    repeat (30) @(posedge pclk);
    chk(dtc_mem_model_inst.waddr_q.size(), 0);
    pulse(k);
    wait_done(2);
    units(1);
    prog(3, 16'h0001, 5'h08);
    apb(1, rg(3, 4), 32'h0000_0001);
    ext_req_pin <= 4'h8;
    repeat (4) @(posedge pclk);
    ext_req_pin <= 4'h0;
    wait_done(3);
    units(1);
    prog(0, 16'h0001, 5'h06);
    dst = 26'h0c0;
    prog(2, 16'h0001, 5'h06);
    apb(1, rg(0, 4), 32'h0000_0001);
    apb(1, rg(2, 4), 32'h0000_0001);
    pulse(6);
    wait_done(2);
    chk(dtc_mem_model_inst.waddr_q.pop_front(), 26'h080);
    chk(dtc_mem_model_inst.waddr_q.pop_front(), 26'h0c0);
    chk(dtc_mem_model_inst.gap_err, 0);
    test_done();
  end

  // whole run needs well under 40000 cycles
  initial begin
    #240000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire

// ### pkg/dtc_pkg.sv
package dtc_pkg;
  localparam int NCH = 4;
  localparam int AW  = 26;
  localparam int DW  = 16;
  localparam int CW  = 16;
  localparam int PAW = 12;
  localparam int NIRQ = 8;

  // per-channel register offsets, channel block stride 0x20
  localparam logic [2:0] IDX_SRC  = 3'h0;  // byte offset 0x00
  localparam logic [2:0] IDX_DST  = 3'h1;  // byte offset 0x04
  localparam logic [2:0] IDX_CNT  = 3'h2;  // byte offset 0x08
  localparam logic [2:0] IDX_ADC  = 3'h3;  // byte offset 0x0C
  localparam logic [2:0] IDX_CTL  = 3'h4;  // byte offset 0x10
  localparam logic [2:0] IDX_TRG  = 3'h5;  // byte offset 0x14
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam int CH_LSB  = 5;
  localparam int IDX_LSB = 2;

  // channel_ctrl fields
  localparam int CTL_EN   = 0;
  localparam int CTL_DONE = 1;
  localparam int CTL_SOFT = 2;
  localparam int CTL_M2M  = 3;
  // addressing_ctrl fields
  localparam int ADC_SIZE    = 0;
  localparam int ADC_SRC_LSB = 1;
  localparam int ADC_DST_LSB = 3;
  localparam int ADC_W       = 5;
  // trigger_select fields
  localparam int TRG_SEL_LSB = 0;
  localparam int TRG_SRC_LSB = 3;
  localparam int TRG_W       = 5;

  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] AM_FIX = 2'h2;
  localparam logic [1:0] TS_PERIPH = 2'h0;
  localparam logic [1:0] TS_EXT    = 2'h1;

  localparam logic [AW-1:0]    RST_ADDR = 26'h000_0000;
  localparam logic [CW-1:0]    RST_CNT  = 16'h0000;
  localparam logic [ADC_W-1:0] RST_ADC  = 5'h00;
  localparam logic [TRG_W-1:0] RST_TRG  = 5'h00;
  localparam logic [CW-1:0]    CNT_LAST = 16'h0001;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_GAP, ST_WRITE} dtc_state_t;
endpackage

// ### verilog/dtc_dma.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dtc_dma (
  input  wire logic                           pclk,         // system clock
  input  wire logic                           presetn,      // async reset
  input  wire logic                           psel,         // apb select
  input  wire logic                           penable,      // apb access
  input  wire logic                           pwrite,       // apb direction
  input  wire logic [dtc_pkg::PAW-1:0]        paddr,        // apb address
  input  wire logic [31:0]                    pwdata,       // apb write data
  output logic [31:0]                         prdata,       // apb read data
  output logic                                pready,       // apb ready
  output logic                                pslverr,      // apb error
  input  wire logic [dtc_pkg::NIRQ-1:0]       periph_irq,   // on-chip irqs
  input  wire logic [dtc_pkg::NCH-1:0]        ext_req_pin,  // pin requests
  output logic                                mem_req,      // bus cycle on
  output logic                                mem_we,       // write cycle
  output logic                                mem_size16,   // halfword unit
  output logic [dtc_pkg::AW-1:0]              mem_addr,     // bus address
  output logic [dtc_pkg::DW-1:0]              mem_wdata,    // write data
  input  wire logic [dtc_pkg::DW-1:0]         mem_rdata,    // read data
  input  wire logic                           mem_ready,    // cycle done
  output logic                                bus_busy,     // bus owned
  output logic [dtc_pkg::NCH-1:0]             xfer_done     // terminal pulse
);
  localparam int NCH = dtc_pkg::NCH;
  localparam int AW  = dtc_pkg::AW;
  localparam int CW  = dtc_pkg::CW;

  function automatic logic [1:0] lowest(input logic [NCH-1:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic [1:0]    mode,
                                         input logic          s16);
    logic [AW-1:0] d;
    d = s16 ? 26'h000_0002 : 26'h000_0001;
    if (mode == dtc_pkg::AM_INC) begin
      return a + d;
    end else if (mode == dtc_pkg::AM_DEC) begin
      return a - d;
    end
    return a;
  endfunction

  // channel state
  logic [NCH-1:0][AW-1:0]               src_addr_reg;
  logic [NCH-1:0][AW-1:0]               dst_addr_reg;
  logic [NCH-1:0][CW-1:0]               xfer_count_reg;
  logic [NCH-1:0][dtc_pkg::ADC_W-1:0]   addressing_ctrl_reg;
  logic [NCH-1:0][dtc_pkg::TRG_W-1:0]   trigger_select_reg;
  logic [NCH-1:0]                       en_reg;
  logic [NCH-1:0]                       done_reg;
  logic [NCH-1:0]                       m2m_reg;
  logic [NCH-1:0]                       pend_reg;

  // engine state
  dtc_pkg::dtc_state_t                  state_reg;
  logic [1:0]                           cur_ch_reg;
  logic [dtc_pkg::DW-1:0]               data_reg;
  logic                                 mem_req_reg;
  logic                                 mem_we_reg;
  logic                                 mem_size16_reg;
  logic [AW-1:0]                        mem_addr_reg;
  logic [dtc_pkg::DW-1:0]               mem_wdata_reg;
  logic [NCH-1:0]                       xfer_done_reg;

  // request inputs
  logic [dtc_pkg::NIRQ-1:0]             irq_prev_reg;
  logic [NCH-1:0]                       ext_meta_reg;
  logic [NCH-1:0]                       ext_sync_reg;
  logic [NCH-1:0]                       ext_prev_reg;

  // apb
  logic                                 pready_reg;
  logic [31:0]                          prdata_reg;

  // ---------------- apb decode ----------------
  wire [1:0] a_ch     = paddr[dtc_pkg::CH_LSB +: 2];
  wire [2:0] a_idx    = paddr[dtc_pkg::IDX_LSB +: 3];
  wire       unmapped = (|paddr[dtc_pkg::PAW-1:dtc_pkg::CH_LSB+2]) ||
                        (a_idx > dtc_pkg::IDX_LAST);
  wire       acc      = psel && penable;
  wire       wr_en    = acc && pwrite && pready_reg && !unmapped;

  wire [31:0] rd_src = 32'(src_addr_reg[a_ch]);
  wire [31:0] rd_dst = 32'(dst_addr_reg[a_ch]);
  wire [31:0] rd_cnt = 32'(xfer_count_reg[a_ch]);
  wire [31:0] rd_adc = 32'(addressing_ctrl_reg[a_ch]);
  wire [31:0] rd_trg = 32'(trigger_select_reg[a_ch]);
  wire [31:0] rd_ctl = 32'({m2m_reg[a_ch], 1'b0, done_reg[a_ch],
                            en_reg[a_ch]});
  wire [31:0] rd_mux =
    unmapped                  ? 32'h0000_0000 :
    (a_idx == dtc_pkg::IDX_SRC) ? rd_src :
    (a_idx == dtc_pkg::IDX_DST) ? rd_dst :
    (a_idx == dtc_pkg::IDX_CNT) ? rd_cnt :
    (a_idx == dtc_pkg::IDX_ADC) ? rd_adc :
    (a_idx == dtc_pkg::IDX_CTL) ? rd_ctl : rd_trg;

  // one wait state so read data comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc && !pready_reg;
      if (acc && !pready_reg) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pready_reg && acc && unmapped;

  // ---------------- request capture ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_reg <= '0;
      ext_meta_reg <= '0;
      ext_sync_reg <= '0;
      ext_prev_reg <= '0;
    end else begin
      irq_prev_reg <= periph_irq;
      ext_meta_reg <= ext_req_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  wire [dtc_pkg::NIRQ-1:0] irq_rise = periph_irq & ~irq_prev_reg;
  wire [NCH-1:0]           ext_rise = ext_sync_reg & ~ext_prev_reg;

  // memory-to-memory channels request on their own while enabled
  wire [NCH-1:0] req_vec  = en_reg & (pend_reg | m2m_reg);
  wire [1:0]     grant    = lowest(req_vec);
  wire           start    = (state_reg == dtc_pkg::ST_IDLE) && (|req_vec);
  wire           unit_end = (state_reg == dtc_pkg::ST_WRITE) && mem_ready;
  wire [CW-1:0]  cnt_cur  = xfer_count_reg[cur_ch_reg];
  wire           terminal = unit_end && (cnt_cur == dtc_pkg::CNT_LAST);
  wire [dtc_pkg::ADC_W-1:0] adc_cur = addressing_ctrl_reg[cur_ch_reg];
  wire [NCH-1:0] below_grant = NCH'((1 << grant) - 1);

  // ---------------- per-channel registers ----------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire wsel   = wr_en && (a_ch == 2'(c));
    wire w_src  = wsel && (a_idx == dtc_pkg::IDX_SRC);
    wire w_dst  = wsel && (a_idx == dtc_pkg::IDX_DST);
    wire w_cnt  = wsel && (a_idx == dtc_pkg::IDX_CNT);
    wire w_adc  = wsel && (a_idx == dtc_pkg::IDX_ADC);
    wire w_ctl  = wsel && (a_idx == dtc_pkg::IDX_CTL);
    wire w_trg  = wsel && (a_idx == dtc_pkg::IDX_TRG);
    wire mine   = unit_end && (cur_ch_reg == 2'(c));
    wire last   = terminal && (cur_ch_reg == 2'(c));
    wire take   = start && (grant == 2'(c));
    wire [2:0] tsel = trigger_select_reg[c][dtc_pkg::TRG_SEL_LSB +: 3];
    wire [1:0] tsrc = trigger_select_reg[c][dtc_pkg::TRG_SRC_LSB +: 2];
    wire hit = ((tsrc == dtc_pkg::TS_PERIPH) && irq_rise[tsel]) ||
               ((tsrc == dtc_pkg::TS_EXT) && ext_rise[c]) ||
               (w_ctl && pwdata[dtc_pkg::CTL_SOFT]);
    wire [1:0] smode = addressing_ctrl_reg[c][dtc_pkg::ADC_SRC_LSB +: 2];
    wire [1:0] dmode = addressing_ctrl_reg[c][dtc_pkg::ADC_DST_LSB +: 2];
    wire       s16   = addressing_ctrl_reg[c][dtc_pkg::ADC_SIZE];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_addr_reg[c]        <= dtc_pkg::RST_ADDR;
        dst_addr_reg[c]        <= dtc_pkg::RST_ADDR;
        xfer_count_reg[c]      <= dtc_pkg::RST_CNT;
        addressing_ctrl_reg[c] <= dtc_pkg::RST_ADC;
        trigger_select_reg[c]  <= dtc_pkg::RST_TRG;
        en_reg[c]              <= 1'b0;
        done_reg[c]            <= 1'b0;
        m2m_reg[c]             <= 1'b0;
        pend_reg[c]            <= 1'b0;
      end else begin
        // hardware stepping after each unit overrides a same-cycle write
        if (mine) begin
          src_addr_reg[c] <= step(src_addr_reg[c], smode, s16);
          dst_addr_reg[c] <= step(dst_addr_reg[c], dmode, s16);
          xfer_count_reg[c] <= xfer_count_reg[c] - 16'h0001;
        end else begin
          if (w_src) src_addr_reg[c] <= pwdata[AW-1:0];
          if (w_dst) dst_addr_reg[c] <= pwdata[AW-1:0];
          if (w_cnt) xfer_count_reg[c] <= pwdata[CW-1:0];
        end
        if (w_adc) begin
          addressing_ctrl_reg[c] <= pwdata[dtc_pkg::ADC_W-1:0];
        end
        if (w_trg) begin
          trigger_select_reg[c] <= pwdata[dtc_pkg::TRG_W-1:0];
        end
        if (w_ctl) begin
          m2m_reg[c] <= pwdata[dtc_pkg::CTL_M2M];
        end
        // terminal clear of enable beats a software enable that cycle
        if (last) begin
          en_reg[c] <= 1'b0;
        end else if (w_ctl) begin
          en_reg[c] <= pwdata[dtc_pkg::CTL_EN];
        end
        // done: hardware set wins over write-one-to-clear
        done_reg[c] <= last ||
                       (done_reg[c] && !(w_ctl && pwdata[dtc_pkg::CTL_DONE]));
        // new request wins over consumption; dropped when disabled
        pend_reg[c] <= en_reg[c] && !last &&
                       (hit || (pend_reg[c] && !take));
      end
    end
  end

  // ---------------- transfer engine ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= dtc_pkg::ST_IDLE;
      cur_ch_reg     <= 2'h0;
      data_reg       <= '0;
      mem_req_reg    <= 1'b0;
      mem_we_reg     <= 1'b0;
      mem_size16_reg <= 1'b0;
      mem_addr_reg   <= dtc_pkg::RST_ADDR;
      mem_wdata_reg  <= '0;
      xfer_done_reg  <= '0;
    end else begin
      xfer_done_reg <= '0;
      unique case (state_reg)
        dtc_pkg::ST_IDLE: begin
          if (start) begin
            cur_ch_reg     <= grant;
            mem_req_reg    <= 1'b1;
            mem_we_reg     <= 1'b0;
            mem_addr_reg   <= src_addr_reg[grant];
            mem_size16_reg <= addressing_ctrl_reg[grant][dtc_pkg::ADC_SIZE];
            state_reg      <= dtc_pkg::ST_READ;
          end
        end
        dtc_pkg::ST_READ: begin
          if (mem_ready) begin
            data_reg    <= mem_size16_reg ? mem_rdata :
                           {8'h00, mem_rdata[7:0]};
            mem_req_reg <= 1'b0;
            state_reg   <= dtc_pkg::ST_GAP;
          end
        end
        dtc_pkg::ST_GAP: begin
          mem_req_reg   <= 1'b1;
          mem_we_reg    <= 1'b1;
          mem_addr_reg  <= dst_addr_reg[cur_ch_reg];
          mem_wdata_reg <= data_reg;
          state_reg     <= dtc_pkg::ST_WRITE;
        end
        dtc_pkg::ST_WRITE: begin
          if (mem_ready) begin
            mem_req_reg <= 1'b0;
            mem_we_reg  <= 1'b0;
            state_reg   <= dtc_pkg::ST_IDLE;
            if (terminal) begin
              xfer_done_reg[cur_ch_reg] <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign mem_req    = mem_req_reg;
  assign mem_we     = mem_we_reg;
  assign mem_size16 = mem_size16_reg;
  assign mem_addr   = mem_addr_reg;
  assign mem_wdata  = mem_wdata_reg;
  assign xfer_done  = xfer_done_reg;
  // idle state between units hands the bus back to the processor
  assign bus_busy   = (state_reg != dtc_pkg::ST_IDLE);

  // ---------------- checks ----------------
  AST_GAP_ONE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_reg == dtc_pkg::ST_READ) && mem_ready |=>
      !mem_req ##1 (mem_req && mem_we))
    else $error("read and write not separated by one idle clock");

  AST_READ_ADDR: assert property (@(posedge pclk)
    disable iff (!presetn)
    start |=> (mem_req && !mem_we && mem_addr == $past(src_addr_reg[grant])))
    else $error("read cycle does not drive the source address");

  AST_WRITE_DATA: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_reg == dtc_pkg::ST_GAP) |=>
      (mem_wdata == data_reg) && (mem_addr == dst_addr_reg[cur_ch_reg]))
    else $error("write cycle address or data wrong");

  AST_RELEASE: assert property (@(posedge pclk)
    disable iff (!presetn)
    unit_end |=> !bus_busy && !mem_req)
    else $error("bus not released after a unit");

  AST_COUNT_DEC: assert property (@(posedge pclk)
    disable iff (!presetn)
    unit_end && !terminal |=> cnt_cur == $past(cnt_cur) - 16'h0001)
    else $error("count not decremented after write");

  AST_TERMINAL: assert property (@(posedge pclk)
    disable iff (!presetn)
    terminal |=> done_reg[cur_ch_reg] && !en_reg[cur_ch_reg] &&
                 xfer_done[cur_ch_reg])
    else $error("terminal count did not stop the channel");

  AST_PRIO: assert property (@(posedge pclk)
    disable iff (!presetn)
    start |-> ((req_vec & below_grant) == '0) && req_vec[grant])
    else $error("lower channel skipped");

  AST_FIXED_SRC: assert property (@(posedge pclk)
    disable iff (!presetn)
    unit_end && (adc_cur[dtc_pkg::ADC_SRC_LSB +: 2] == dtc_pkg::AM_FIX) |=>
      $stable(src_addr_reg[cur_ch_reg]))
    else $error("fixed source address moved");

  AST_DISABLED_IDLE: assert property (@(posedge pclk)
    disable iff (!presetn)
    (en_reg == '0) && (state_reg == dtc_pkg::ST_IDLE) |=> !mem_req)
    else $error("transfer started with no channel enabled");
endmodule
`default_nettype wire
